//--- core/lpddr_core.sv
// device-side access core: command decode, bank state and 8n bursts
//
// Operation
// - eight independent banks, chosen by the bank bits of each command.
// - command, address and bank travel on one ten-bit bus.
// - one command per clock, bus sampled on rising and falling edge.
// - data pins carry two beats per clock from an 8n prefetch.
// - one 8n-wide core word per access, eight n-wide half-clock beats.
// - bursts start at chosen column, run eight beats in wrapping order.
// - activate opens row and bank before any read or write.
// - read or write bits select bank and starting column.
// - device keeps outputs high impedance while CKE is low.
`timescale 1ns/1ps
`default_nettype none
module lpddr_core
  import lpddr_pkg::*;
(
  // core clock and reset
  input  wire logic            i_core_clk,
  input  wire logic            i_sys_rst,
  // memory clock and control pins
  input  wire logic            i_ck,
  input  wire logic            i_cke,
  input  wire logic            i_cs_n,
  input  wire logic [CA_W-1:0] i_ca,
  // data pins
  input  wire logic [DQ_W-1:0] i_dq,
  output logic      [DQ_W-1:0] o_dq,
  output logic                 o_dq_oe,
  // bank status
  output logic      [BANKS-1:0] o_bank_open
);

  // ********************************
  // pin synchronisation
  // ********************************
  logic [SYNC_W-1:0] pins_s;
  logic              ck_s;
  logic              cke_s;
  logic              cs_n_s;
  logic [CA_W-1:0]   ca_s;
  logic [DQ_W-1:0]   dq_s;

  // all pins share one delay, so ck edges stay aligned with their data
  lpddr_sync #(.WIDTH(SYNC_W)) u_sync
  (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_pins     ({i_ck, i_cke, i_cs_n, i_ca, i_dq}),
    .o_sync     (pins_s)
  );

  assign {ck_s, cke_s, cs_n_s, ca_s, dq_s} = pins_s;

  // ********************************
  // state
  // ********************************
  typedef struct packed
  {
    logic                              ck_prev;
    logic                              powered;
    logic                              cs_rise;
    logic [CA_W-1:0]                   ca_rise;
    logic [BANKS-1:0]                  bank_open;
    logic [BANKS-1:0][ROW_W-1:0]       open_row;
    phase_e                            phase;
    logic [BA_W-1:0]                   bank;
    logic                              slot;
    logic [BEAT_W-1:0]                 start;
    logic [BEAT_W-1:0]                 beat;
    logic [BEAT_W-1:0]                 lat;
    logic [DQ_W-1:0]                   dq;
    logic                              dq_oe;
    logic [MEM_DEPTH-1:0][LINE_W-1:0]  mem;
  } core_s;

  core_s st;
  core_s next_st;

  logic              rise;
  logic              fall;
  logic              any_edge;
  logic              cmd_ok;
  logic              cmd_act;
  logic              cmd_rd;
  logic              cmd_wr;
  logic              cmd_pre;
  logic [BA_W-1:0]   cmd_ba;
  logic [ROW_W-1:0]  cmd_row;
  logic [BEAT_W-1:0] col_start;
  logic [BEAT_W-1:0] beat_sel;
  logic [IDX_W-1:0]  idx;
  logic [DQ_W-1:0]   rd_word;

  // ********************************
  // edge finding and command decode
  // ********************************
  assign rise     = ck_s & ~st.ck_prev;
  assign fall     = ~ck_s & st.ck_prev;
  assign any_edge = rise | fall;
  // a command is complete once its falling half has been seen
  assign cmd_ok   = fall & st.cs_rise & st.powered;
  assign cmd_act  = cmd_ok & (st.ca_rise[1:0] == CMD_ACT);
  assign cmd_rd   = cmd_ok & (st.ca_rise[2:0] == CMD_READ);
  assign cmd_wr   = cmd_ok & (st.ca_rise[2:0] == CMD_WRITE);
  assign cmd_pre  = cmd_ok & (st.ca_rise[3:0] == CMD_PRE);
  assign cmd_ba   = st.ca_rise[BA_LSB +: BA_W];
  assign cmd_row  = {st.ca_rise[ROW_HI_LSB +: 5], ca_s};
  assign col_start = {st.ca_rise[C2_POS], st.ca_rise[C1_POS], 1'b0};

  // wrapping order inside the eight-beat line
  assign beat_sel = st.start + st.beat;
  assign idx      = {st.bank, st.slot};
  assign rd_word  = st.mem[idx][beat_sel*DQ_W +: DQ_W];

  always_comb
  begin
    next_st         = st;
    next_st.ck_prev = ck_s;

    if (rise)
    begin
      // cs is sampled on the rising half only
      next_st.cs_rise = ~cs_n_s & cke_s;
      next_st.ca_rise = ca_s;
      if (cke_s)
        next_st.powered = 1'b1;
    end

    if (cmd_act)
    begin
      next_st.bank_open[cmd_ba] = 1'b1;
      next_st.open_row[cmd_ba]  = cmd_row;
    end

    if (cmd_pre)
    begin
      if (st.ca_rise[ALL_BANK])
        next_st.bank_open = '0;
      else
        next_st.bank_open[cmd_ba] = 1'b0;
    end

    // ********************************
    // burst engine
    // ********************************
    case (st.phase)
      PH_IDLE:
      begin
        // last beat is held for one half clock, then the pins are released
        if (any_edge)
          next_st.dq_oe = 1'b0;
        // accesses to a closed bank are dropped silently
        if ((cmd_rd | cmd_wr) & st.bank_open[cmd_ba])
        begin
          next_st.phase = cmd_rd ? PH_READ : PH_WRITE;
          next_st.bank  = cmd_ba;
          next_st.slot  = ca_s[SLOT_POS];
          next_st.start = col_start;
          next_st.beat  = '0;
          next_st.lat   = LAT_EDGES;
        end
      end
      PH_READ,
      PH_WRITE:
      begin
        if (any_edge)
        begin
          if (st.lat != '0)
            next_st.lat = st.lat - 3'h1;
          else
          begin
            // one beat per clock edge, i.e. double data rate
            if (st.phase == PH_READ)
            begin
              next_st.dq    = rd_word;
              next_st.dq_oe = 1'b1;
            end
            else
              next_st.mem[idx][beat_sel*DQ_W +: DQ_W] = dq_s;
            next_st.beat = st.beat + 3'h1;
            if (st.beat == LAST_BEAT)
              next_st.phase = PH_IDLE;
          end
        end
      end
      default:
        next_st.phase = PH_IDLE;
    endcase

    // relies on the controller holding cke low through the ramp
    if (!cke_s)
      next_st.dq_oe = 1'b0;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st <= '{phase: PH_IDLE, default: '0};
    else
      st <= next_st;
  end

  assign o_dq        = st.dq;
  assign o_dq_oe     = st.dq_oe;
  assign o_bank_open = st.bank_open;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_hiz_cke_low: assert property (!cke_s |=> !o_dq_oe)
    else $error("data pins driven while cke low");

  a_act_opens_bank: assert property (
    cmd_act |=> o_bank_open[$past(cmd_ba)])
    else $error("activate did not open its bank");

  a_closed_bank_ignored: assert property (
    (cmd_rd | cmd_wr) && !st.bank_open[cmd_ba] && st.phase == PH_IDLE
    |=> st.phase == PH_IDLE)
    else $error("access started on a closed bank");

  // bank state may only move once a command's falling half is seen
  a_cmd_on_fall: assert property (
    !fall |=> $stable(o_bank_open))
    else $error("bank state changed away from a falling edge");

  a_ca_capture: assert property (
    rise |=> st.ca_rise == $past(ca_s))
    else $error("command bus not captured on rising edge");

  a_col_select: assert property (
    cmd_rd && st.bank_open[cmd_ba] && st.phase == PH_IDLE
    |=> st.start == $past(col_start) && st.bank == $past(cmd_ba))
    else $error("burst start column or bank wrong");

  a_dq_on_edge: assert property (
    $changed(o_dq) |-> $past(any_edge))
    else $error("data changed away from a clock edge");

  // the beat still lands with cke low, but the pins stay released
  a_beat_data: assert property (
    st.phase == PH_READ && any_edge && st.lat == '0
    |=> o_dq == $past(rd_word) && o_dq_oe == $past(cke_s))
    else $error("read beat carries wrong word");

  a_burst_end: assert property (
    st.phase != PH_IDLE && any_edge && st.lat == '0 && st.beat == LAST_BEAT
    |=> st.phase == PH_IDLE)
    else $error("burst did not end after eight beats");

endmodule
`default_nettype wire

//--- shared/lpddr_pkg.sv
// constants and types shared by the low-power DDR device core
package lpddr_pkg;

  // ********************************
  // organisation
  // ********************************
  localparam int CA_W      = 10;
  localparam int DQ_W      = 32;
  localparam int BANKS     = 8;
  localparam int BA_W      = 3;
  localparam int ROW_W     = 15;
  localparam int BURST     = 8;
  localparam int BEAT_W    = 3;
  localparam int MEM_DEPTH = 16;
  localparam int IDX_W     = 4;
  localparam int LINE_W    = BURST * DQ_W;
  localparam int SYNC_W    = 3 + CA_W + DQ_W;

  // ********************************
  // command/address field positions
  // ********************************
  localparam int BA_LSB      = 7;
  localparam int ROW_HI_LSB  = 2;
  localparam int C1_POS      = 5;
  localparam int C2_POS      = 6;
  localparam int SLOT_POS    = 1;
  localparam int ALL_BANK    = 4;

  // ********************************
  // command codes on the rising edge
  // ********************************
  localparam logic [1:0] CMD_ACT   = 2'h2;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [3:0] CMD_PRE   = 4'hb;

  // ********************************
  // burst timing, counted in clock edges
  // ********************************
  localparam logic [BEAT_W-1:0] LAT_EDGES = 3'h2;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;

  typedef enum logic [2:0]
  {
    PH_IDLE  = 3'b001,
    PH_READ  = 3'b010,
    PH_WRITE = 3'b100
  } phase_e;

endpackage

//--- core/lpddr_sync.sv
// two-flop synchroniser bank for the device pins
`timescale 1ns/1ps
`default_nettype none
module lpddr_sync
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // first stage is read only by the second
  always_comb
  begin
    next_st.meta   = i_pins;
    next_st.stable = st.meta;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_sync = st.stable;

endmodule
`default_nettype wire

//--- dv/lpddr_ctrl_model.sv
// memory controller model driving the device pins
`timescale 1ns/1ps
`default_nettype none
module lpddr_ctrl_model
  import lpddr_pkg::*;
(
  // clock and read side
  input  wire logic            i_core_clk,
  input  wire logic [DQ_W-1:0] i_dq,
  input  wire logic            i_dq_oe,
  // device pins
  output logic                 o_ck,
  output logic                 o_cke,
  output logic                 o_cs_n,
  output logic      [CA_W-1:0] o_ca,
  output logic      [DQ_W-1:0] o_dq
);
  // nop idle at a 48 ns clock, rounded up so it is never short
  localparam int TINIT3 = (200000 + 47) / 48;
  logic            cke_q;
  logic [DQ_W-1:0] rd_q[$];
  initial
  begin
    o_ck   = 1'b0;
    o_cke  = 1'b0;
    o_cs_n = 1'b1;
    o_ca   = '0;
    o_dq   = '0;
    cke_q  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // read beats are taken six core cycles after each ck edge
  task automatic take();
    // mid-beat sampling leaves room for a late, unconfigured strobe
    if (i_dq_oe === 1'b1)
      rd_q.push_back(i_dq);
  endtask
  // one ck period; a released line shows the inverse of its last value
  task automatic cyc(input logic cs_n, input logic [CA_W-1:0] rca,
    input logic [CA_W-1:0] fca, input logic wr,
    input logic [DQ_W-1:0] dr, input logic [DQ_W-1:0] df);
    @(posedge i_core_clk);
    o_cke  <= cke_q;
    o_cs_n <= cs_n;
    o_ca   <= cs_n ? ~o_ca : rca;
    o_dq   <= wr ? dr : ~o_dq;
    tick(3);
    take();
    // one boot-range clock serves every command, init included
    o_ck <= 1'b1;
    tick(3);
    o_ca <= cs_n ? ~o_ca : fca;
    o_dq <= wr ? df : ~o_dq;
    tick(3);
    take();
    o_ck <= 1'b0;
    tick(2);
  endtask
  task automatic nop();
    cyc(1'b1, '0, '0, 1'b0, '0, '0);
  endtask
  task automatic power_up();
    repeat (5) nop();
    // ca and dq invert every half clock, cke high or not; cs_n holds and ck keeps toggling
    cke_q = 1'b1;
    repeat (TINIT3) nop();
  endtask
endmodule
`default_nettype wire

//--- dv/test_lpddr_core_access_and_powerup.sv
// self-checking bench for the device access core
`timescale 1ns/1ps
`default_nettype none
module test_lpddr_core_access_and_powerup
  import lpddr_pkg::*;
;
  logic             i_core_clk;
  logic             i_sys_rst;
  logic             ck;
  logic             cke;
  logic             cs_n;
  logic [CA_W-1:0]  ca;
  logic [DQ_W-1:0]  dq_in;
  logic [DQ_W-1:0]  dq_out;
  logic             dq_oe;
  logic [BANKS-1:0] bank_open;
  int               error_cnt;
  int               samples_checked;
  lpddr_core lpddr_core_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_ck(ck), .i_cke(cke), .i_cs_n(cs_n), .i_ca(ca), .i_dq(dq_in),
    .o_dq(dq_out), .o_dq_oe(dq_oe), .o_bank_open(bank_open));
  lpddr_ctrl_model lpddr_ctrl_model_inst (.i_core_clk(i_core_clk),
    .i_dq(dq_out), .i_dq_oe(dq_oe), .o_ck(ck), .o_cke(cke),
    .o_cs_n(cs_n), .o_ca(ca), .o_dq(dq_in));
  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [DQ_W-1:0] seen,
    input logic [DQ_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [DQ_W-1:0] pat(input logic [7:0] s, input int i);
    return {s, 8'(i), ~s, 8'h5a};
  endfunction
  task automatic nop();
    lpddr_ctrl_model_inst.nop();
  endtask
  task automatic cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
    lpddr_ctrl_model_inst.cyc(1'b0, r, f, 1'b0, '0, '0);
    lpddr_ctrl_model_inst.tick(3);
  endtask
  task automatic act(input logic [BA_W-1:0] b);
    cmd({b, 5'h0a, CMD_ACT}, 10'h155);
  endtask
  // slot 1 always; start word is twice sc
  task automatic rw(input logic [2:0] op, input logic [BA_W-1:0] b,
    input logic [1:0] sc);
    cmd({b, sc[1], sc[0], 2'h0, op}, 10'h002);
  endtask
  task automatic wr(input logic [BA_W-1:0] b, input logic [7:0] s);
    rw(CMD_WRITE, b, 2'h1);
    // two latency edges pass before the first beat is taken
    nop();
    for (int j = 0; j < 4; j++)
      lpddr_ctrl_model_inst.cyc(1'b1, '0, '0, 1'b1, pat(s, 2 * j),
        pat(s, 2 * j + 1));
    repeat (2) nop();
  endtask
  task automatic rd(input logic [BA_W-1:0] b, input logic [1:0] sc);
    lpddr_ctrl_model_inst.rd_q.delete();
    rw(CMD_READ, b, sc);
    repeat (6) nop();
  endtask
  task automatic t_cke_low();
    act(3'h5);
    rd(3'h5, 2'h0);
    check(32'(bank_open), '0);
    check(32'(lpddr_ctrl_model_inst.rd_q.size()), '0);
  endtask
  task automatic t_banks();
    for (int b = 0; b < BANKS; b++)
    begin
      act(BA_W'(b));
      check(32'(bank_open), (32'h2 << b) - 32'h1);
    end
  endtask
  task automatic t_pre();
    cmd({3'h6, 3'h0, CMD_PRE}, '0);
    check(32'(bank_open), 32'hbf);
    cmd(10'h01b, '0);
    check(32'(bank_open), '0);
    rd(3'h2, 2'h0);
    check(32'(lpddr_ctrl_model_inst.rd_q.size()), '0);
  endtask
  task automatic t_burst();
    act(3'h3);
    act(3'h4);
    wr(3'h3, 8'h3c);
    wr(3'h4, 8'h4d);
    rd(3'h3, 2'h3);
    check(32'(lpddr_ctrl_model_inst.rd_q.size()), 32'h8);
    for (int i = 0; i < 8; i++)
      check(lpddr_ctrl_model_inst.rd_q[i],
        pat(8'h3c, (i + 4) % 8));
  endtask
  // clock enable dropped with a burst under way
  task automatic t_cke_drop();
    rw(CMD_READ, 3'h4, 2'h0);
    repeat (2) nop();
    check(32'(dq_oe), 32'h1);
    lpddr_ctrl_model_inst.cke_q = 1'b0;
    nop();
    check(32'(dq_oe), '0);
  endtask
  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    check(dq_out | 32'(dq_oe), '0);
    t_cke_low();
    lpddr_ctrl_model_inst.power_up();
    t_banks();
    t_pre();
    t_burst();
    t_cke_drop();
    test_done();
  end
  // the run needs about 203 us
  initial
  begin
    #400000;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
